// *** design/external_memory_interface.sv ***
`timescale 1ns/100ps
`include "external_memory_port_defines.svh"
// Contract
// - low address and data share one bus; high address bus has selectable width
// - enabled port overrides port direction settings on its pins
// - address decides internal or external; external drives address, data, control
// - low address stays valid when the latch pulse falls
// - latch pulse stays low throughout the data phase
// - internal accesses may show bus activity but never strobes
// - disabled port returns pins to port settings, but in legacy mode control pins stay outputs; high addresses not mapped inside
// - bus keeper holds last level on undriven multiplexed lines
// - pull-ups active on undriven lines where port output bit is one
// - four software-selected wait settings including zero wait
// - two sectors with independent wait settings
// - legacy mode offers only upper-sector codes for zero or one wait
// - legacy mode: fixed high bits, no sectors, no keeper, output-only controls
// - legacy mode hides both extended control registers and their features
// - control bits spread over three registers
// - enable bit switches pins to interface functions; clearing disables
// - wait code: none, one, two strobe cycles, or two plus address gap
// - sector code places boundary in 8 KB steps; zero means one sector
// - mask code releases high address pins from the top bit down
module external_memory_interface
  import external_memory_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compat_mode,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic mem_ext,
  input wire logic [7:0] port_ad_out,
  input wire logic [7:0] port_ad_dir,
  input wire logic [7:0] port_ha_out,
  input wire logic [7:0] port_ha_dir,
  input wire logic [2:0] port_ctl_out,
  input wire logic [2:0] port_ctl_dir,
  input wire logic [7:0] mux_addr_data_bus_i,
  output logic [7:0] mux_addr_data_bus_o,
  output logic [7:0] mux_addr_data_bus_oe,
  output logic [7:0] high_address_bus_o,
  output logic [7:0] high_address_bus_oe,
  output logic ale_o,
  output logic ale_oe,
  output logic rd_n_o,
  output logic rd_n_oe,
  output logic wr_n_o,
  output logic wr_n_oe,
  output logic [7:0] ad_pullup_en,
  output logic [7:0] ad_keeper_en,
  output logic [7:0] ad_keeper_val
);

  function automatic logic [3:0] wait_extra(input wait_code_t code);
    case (code)
      2'b00: wait_extra = 4'h0;
      2'b01: wait_extra = 4'h1;
      default: wait_extra = 4'h2;
    endcase
  endfunction : wait_extra

  function automatic logic in_lower(input logic [15:0] addr,
                                    input logic [2:0] bcode);
    in_lower = addr[`SECT_HI:`SECT_LO] < bcode;
  endfunction : in_lower

  function automatic logic [7:0] high_mask(input logic [2:0] mcode);
    case (mcode)
      3'h0: high_mask = 8'hff;
      3'h1: high_mask = 8'h7f;
      3'h2: high_mask = 8'h3f;
      3'h3: high_mask = 8'h1f;
      3'h4: high_mask = 8'h0f;
      3'h5: high_mask = 8'h07;
      3'h6: high_mask = 8'h03;
      default: high_mask = 8'h00;
    endcase
  endfunction : high_mask

  function automatic logic reg_ok(input logic [7:0] a, input logic is_wr,
                                  input logic legacy);
    reg_ok = (a == `OFF_CTRL) || (!legacy && (a == `OFF_XA))
      || (!legacy && (a == `OFF_XB)) || (!is_wr && (a == `OFF_STAT));
  endfunction : reg_ok

  logic [7:0] ctrl_r;
  logic [7:0] xa_r;
  logic [7:0] xb_r;
  logic reg_wr_en;
  logic [7:0] reg_wr_addr;
  logic [7:0] reg_wr_data;
  logic [7:0] reg_rd_addr;
  logic [7:0] reg_rd_data;
  logic [7:0] stat_word;
  logic wr_ok;
  logic rd_ok;

  axil_slave u_bus (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(reg_wr_en),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .wr_ok(wr_ok),
    .rd_addr(reg_rd_addr),
    .rd_data(reg_rd_data),
    .rd_ok(rd_ok)
  );

  logic [7:0] ad_sync;

  pin_sync8 u_ad_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(mux_addr_data_bus_i),
    .level_out(ad_sync)
  );

  // register access decode
  assign wr_ok = reg_ok(reg_wr_addr, 1'b1, compat_mode);
  assign rd_ok = reg_ok(reg_rd_addr, 1'b0, compat_mode);
  assign reg_rd_data = (reg_rd_addr == `OFF_CTRL) ? ctrl_r :
    (rd_ok && reg_rd_addr == `OFF_XA) ? xa_r :
    (rd_ok && reg_rd_addr == `OFF_XB) ? xb_r :
    (reg_rd_addr == `OFF_STAT) ? stat_word : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET;
      xa_r <= `XA_RESET;
      xb_r <= `XB_RESET;
    end else if (reg_wr_en && wr_ok) begin
      case (reg_wr_addr)
        `OFF_CTRL: ctrl_r <= reg_wr_data & `CTRL_RW_MASK;
        `OFF_XA: xa_r <= reg_wr_data & `XA_RW_MASK;
        `OFF_XB: xb_r <= reg_wr_data & `XB_RW_MASK;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // effective configuration
  logic en;
  logic keeper_on;
  logic [2:0] bound_code;
  logic [2:0] mask_code;
  wait_code_t lower_code;
  wait_code_t upper_code;
  logic [7:0] ha_active;

  assign en = ctrl_r[`CTRL_EN_BIT];
  assign keeper_on = !compat_mode && xb_r[`XB_KEEP_BIT];
  assign bound_code = compat_mode ? 3'h0
    : xa_r[`XA_SRL_HI:`XA_SRL_LO];
  assign mask_code = compat_mode ? 3'h0
    : xb_r[`XB_MASK_HI:`XB_MASK_LO];
  assign lower_code = xa_r[`XA_LW_HI:`XA_LW_LO];
  assign upper_code = {!compat_mode && xa_r[`XA_UWH_BIT],
                       ctrl_r[`CTRL_UWL_BIT]};
  assign ha_active = en ? high_mask(mask_code) : 8'h00;

  // access sequencer
  external_memory_port_state_e state_r;
  external_memory_port_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [15:0] acc_addr_r;
  logic [7:0] acc_wdata_r;
  logic acc_we_r;
  logic acc_ext_r;
  logic acc_upper_r;
  wait_code_t acc_code_r;
  logic req_ok;
  logic req_ext;
  logic req_lower;
  logic start;
  logic ack_nxt;
  logic strobe_last;
  logic [3:0] strobe_len;

  assign req_ok = mem_req && !mem_ack;
  assign req_ext = mem_addr >= `INT_SRAM_END;
  assign req_lower = in_lower(mem_addr, bound_code);
  // base strobe covers the input synchroniser latency
  assign strobe_len = `STROBE_BASE + wait_extra(acc_code_r);
  assign strobe_last = cnt_r == strobe_len - 4'h1;
  assign stat_word = {5'h00, acc_upper_r, mem_ext, state_r != ST_IDLE};

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ack_nxt = 1'b0;
    start = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (req_ok && en) begin
          state_nxt = ST_ADDR;
          start = 1'b1;
        end else if (req_ok) begin
          ack_nxt = 1'b1;
        end
      end
      ST_ADDR: state_nxt = ST_LATCH;
      ST_LATCH: begin
        state_nxt = ST_STROBE;
        cnt_nxt = 4'h0;
      end
      ST_STROBE: begin
        if (strobe_last) begin
          state_nxt = ST_RECOV;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      ST_RECOV: begin
        if (acc_code_r == `GAP_CODE) begin
          state_nxt = ST_GAP;
        end else begin
          state_nxt = ST_IDLE;
          ack_nxt = 1'b1;
        end
      end
      ST_GAP: begin
        state_nxt = ST_IDLE;
        ack_nxt = 1'b1;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      acc_addr_r <= 16'h0000;
      acc_wdata_r <= 8'h00;
      acc_we_r <= 1'b0;
      acc_ext_r <= 1'b0;
      acc_upper_r <= 1'b0;
      acc_code_r <= 2'b00;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      mem_ext <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mem_ack <= ack_nxt;
      if (start) begin
        acc_addr_r <= mem_addr;
        acc_wdata_r <= mem_wdata;
        acc_we_r <= mem_we;
        acc_ext_r <= req_ext;
        acc_upper_r <= !req_lower;
        acc_code_r <= req_lower ? lower_code : upper_code;
        mem_ext <= req_ext;
      end else if (state_r == ST_IDLE && req_ok) begin
        mem_ext <= req_ext;
        mem_rdata <= 8'h00;
      end
      if (state_r == ST_STROBE && strobe_last && !acc_we_r) begin
        mem_rdata <= acc_ext_r ? ad_sync : 8'h00;
      end
    end
  end

  // pin values, registered below
  logic drive_addr;
  logic drive_data;
  logic strobe_act;
  logic [7:0] ad_o_nxt;
  logic [7:0] ad_oe_nxt;
  logic [7:0] keep_val_nxt;

  assign drive_addr = state_r == ST_ADDR || state_r == ST_LATCH;
  assign drive_data = acc_we_r
    && (state_r == ST_STROBE || state_r == ST_RECOV);
  assign strobe_act = state_r == ST_STROBE && acc_ext_r;
  assign ad_o_nxt = !en ? port_ad_out
    : drive_addr ? acc_addr_r[7:0] : acc_wdata_r;
  assign ad_oe_nxt = !en ? port_ad_dir
    : {8{drive_addr || drive_data}};
  assign keep_val_nxt = (mux_addr_data_bus_oe & mux_addr_data_bus_o)
    | (~mux_addr_data_bus_oe & ad_sync);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mux_addr_data_bus_o <= 8'h00;
      mux_addr_data_bus_oe <= 8'h00;
      high_address_bus_o <= 8'h00;
      high_address_bus_oe <= 8'h00;
      ale_o <= 1'b0;
      ale_oe <= 1'b0;
      rd_n_o <= 1'b1;
      rd_n_oe <= 1'b0;
      wr_n_o <= 1'b1;
      wr_n_oe <= 1'b0;
      ad_pullup_en <= 8'h00;
      ad_keeper_en <= 8'h00;
      ad_keeper_val <= 8'h00;
    end else begin
      mux_addr_data_bus_o <= ad_o_nxt;
      mux_addr_data_bus_oe <= ad_oe_nxt;
      high_address_bus_o <= (ha_active & acc_addr_r[15:8])
        | (~ha_active & port_ha_out);
      high_address_bus_oe <= ha_active | port_ha_dir;
      ale_o <= en ? state_r == ST_ADDR : port_ctl_out[2];
      ale_oe <= en || compat_mode || port_ctl_dir[2];
      rd_n_o <= en ? !(strobe_act && !acc_we_r) : port_ctl_out[0];
      rd_n_oe <= en || compat_mode || port_ctl_dir[0];
      wr_n_o <= en ? !(strobe_act && acc_we_r) : port_ctl_out[1];
      wr_n_oe <= en || compat_mode || port_ctl_dir[1];
      ad_pullup_en <= port_ad_out & ~ad_oe_nxt;
      ad_keeper_en <= {8{keeper_on}} & ~ad_oe_nxt;
      ad_keeper_val <= keep_val_nxt;
    end
  end

endmodule : external_memory_interface

// *** inc/external_memory_port_defines.svh ***
`ifndef EXTERNAL_MEMORY_PORT_DEFINES_SVH
`define EXTERNAL_MEMORY_PORT_DEFINES_SVH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_XA 8'h04
`define OFF_XB 8'h08
`define OFF_STAT 8'h0c

// reset values
`define CTRL_RESET 8'h00
`define XA_RESET 8'h00
`define XB_RESET 8'h00

// writable bits; reserved bits read as zero
`define CTRL_RW_MASK 8'hff
`define XA_RW_MASK 8'h7e
`define XB_RW_MASK 8'h87

// field positions
`define CTRL_EN_BIT 7
`define CTRL_UWL_BIT 6
`define XA_SRL_HI 6
`define XA_SRL_LO 4
`define XA_LW_HI 3
`define XA_LW_LO 2
`define XA_UWH_BIT 1
`define XB_KEEP_BIT 7
`define XB_MASK_HI 2
`define XB_MASK_LO 0
`define STAT_BUSY_BIT 0
`define STAT_EXT_BIT 1
`define STAT_UPPER_BIT 2

// first data address beyond on-chip sram
`define INT_SRAM_END 16'h1100

// sector boundary step is 8 KB: boundary index is addr[15:13]
`define SECT_HI 15
`define SECT_LO 13

// timing in system clock cycles
`define STROBE_BASE 4'h6
`define GAP_CODE 2'b11

// axi responses
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// *** inc/external_memory_port_pkg.sv ***
package external_memory_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_LATCH = 3'b010,
    ST_STROBE = 3'b011,
    ST_RECOV = 3'b100,
    ST_GAP = 3'b101
  } external_memory_port_state_e;

  typedef logic [1:0] wait_code_t;

endpackage : external_memory_port_pkg

// *** design/pin_sync8.sv ***
`timescale 1ns/100ps
module pin_sync8 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] pin_in,
  output logic [7:0] level_out
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic [7:0] level_nxt;

  // a bit changes only once stages two and three agree
  assign level_nxt = (s2_r & s3_r) | (level_out & (s2_r | s3_r));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      level_out <= 8'h00;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_out <= level_nxt;
    end
  end
endmodule : pin_sync8

// *** design/axil_slave.sv ***
`timescale 1ns/100ps
`include "external_memory_port_defines.svh"
module axil_slave (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);
  logic aw_got_r;
  logic w_got_r;
  logic wstrb0_r;
  logic ar_got_r;
  logic aw_take;
  logic w_take;
  logic commit;
  logic aw_got_nxt;
  logic w_got_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;
  logic ar_got_nxt;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign commit = aw_got_r && w_got_r && !s_axi_bvalid;
  // only byte lane 0 carries register data
  assign wr_en = commit && wstrb0_r;
  assign aw_got_nxt = (aw_got_r || aw_take) && !commit;
  assign w_got_nxt = (w_got_r || w_take) && !commit;
  assign bvalid_nxt = commit || (s_axi_bvalid && !s_axi_bready);
  assign ar_got_nxt = (ar_got_r || (s_axi_arvalid && s_axi_arready))
    && !(ar_got_r && !s_axi_rvalid);
  assign rvalid_nxt = (ar_got_r && !s_axi_rvalid)
    || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      wstrb0_r <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      s_axi_awready <= !aw_got_nxt && !bvalid_nxt;
      s_axi_wready <= !w_got_nxt && !bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (commit) begin
        s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ar_got_r <= 1'b0;
      rd_addr <= 8'h00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      ar_got_r <= ar_got_nxt;
      s_axi_arready <= !ar_got_nxt && !rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
      end
      if (ar_got_r && !s_axi_rvalid) begin
        s_axi_rdata <= {24'h00_0000, rd_data};
        s_axi_rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
      end
    end
  end
endmodule : axil_slave

// *** verification/external_memory_port_assertions.sv ***
`timescale 1ns/100ps
module external_memory_port_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mux_addr_data_bus_o,
  input wire logic [7:0] mux_addr_data_bus_oe,
  input wire logic ale_o,
  input wire logic ale_oe,
  input wire logic rd_n_o,
  input wire logic rd_n_oe,
  input wire logic wr_n_o,
  input wire logic wr_n_oe,
  input wire logic [7:0] port_ad_out,
  input wire logic [7:0] ad_pullup_en,
  input wire logic [7:0] ad_keeper_en
);
  logic [3:0] low_cnt_r;
  logic [2:0] up_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      low_cnt_r <= 4'h0;
      up_cnt_r <= 3'h0;
    end else begin
      low_cnt_r <= rd_n_o ? 4'h0 : low_cnt_r + 4'h1;
      up_cnt_r <= up_cnt_r + {2'h0, up_cnt_r != 3'h7};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // registered outputs need a few settled cycles
  sequence quiet_s;
    ($stable(port_ad_out) && $stable(mux_addr_data_bus_oe))[*3];
  endsequence
  sequence latch_s;
    $fell(ale_o);
  endsequence
  strobe_internal_a: assert property (
    mem_req && mem_addr < 16'h1100 |-> rd_n_o && wr_n_o)
    else $error("strobe during internal access");
  addr_latch_a: assert property (
    latch_s |-> $stable(mux_addr_data_bus_o) && mux_addr_data_bus_oe == 8'hff)
    else $error("address not held at latch fall");
  ale_data_a: assert property (
    !rd_n_o || !wr_n_o |-> !ale_o)
    else $error("latch pulse high in data phase");
  read_release_a: assert property (
    !rd_n_o |-> mux_addr_data_bus_oe == 8'h00)
    else $error("bus driven during read");
  write_drive_a: assert property (
    !wr_n_o |-> mux_addr_data_bus_oe == 8'hff)
    else $error("bus not driven during write");
  strobe_width_a: assert property (
    $rose(rd_n_o) |-> low_cnt_r inside {4'h6, 4'h7, 4'h8})
    else $error("read strobe width wrong");
  own_pins_a: assert property (
    !rd_n_o |-> rd_n_oe && ale_oe && wr_n_oe)
    else $error("strobe without pin ownership");
  pullup_a: assert property (
    quiet_s ##0 up_cnt_r == 3'h7 |->
      ad_pullup_en == (port_ad_out & ~mux_addr_data_bus_oe))
    else $error("pull-up enables wrong");
  keeper_a: assert property (
    quiet_s |-> (ad_keeper_en & mux_addr_data_bus_oe) == 8'h00)
    else $error("keeper on a driven line");
  ack_pulse_a: assert property (
    mem_ack |=> !mem_ack)
    else $error("ack longer than one cycle");
endmodule : external_memory_port_checker

bind external_memory_interface external_memory_port_checker u_chk (
  .sys_clk, .rst_n, .mem_req, .mem_addr, .mem_ack, .mux_addr_data_bus_o,
  .mux_addr_data_bus_oe, .ale_o, .ale_oe, .rd_n_o, .rd_n_oe, .wr_n_o,
  .wr_n_oe, .port_ad_out, .ad_pullup_en, .ad_keeper_en);

// *** verification/ext_mem_model.sv ***
`timescale 1ns/100ps
module ext_mem_model (
  input wire logic sys_clk,
  input wire logic [1:0] slow,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] ad_o,
  input wire logic [7:0] ad_oe,
  input wire logic [7:0] ha_o,
  input wire logic [7:0] ha_oe,
  input wire logic [7:0] pull,
  input wire logic [7:0] keep_en,
  input wire logic [7:0] keep_val,
  output logic [7:0] ad_pin
);
  logic [7:0] mem [0:65535];
  logic [7:0] low_q;
  logic [7:0] last_r = 8'h00;
  logic [2:0] rd_cnt = 3'h0;
  wire logic [15:0] addr = {ha_o & ha_oe, low_q};
  wire logic drv = !rd_n && rd_cnt >= {1'b0, slow};
  // undriven lines: keeper, then pull-up, else a changing pattern
  wire logic [7:0] idle = (keep_en & keep_val) | (~keep_en & (pull | ~last_r));
  // transparent latch, no clock phase assumed
  always_latch if (ale) low_q <= ad_pin;
  always @(posedge sys_clk) begin
    last_r <= ad_pin;
    rd_cnt <= rd_n ? 3'h0 : rd_cnt + 3'h1;
    if (!wr_n) mem[addr] <= ad_pin;
  end
  assign ad_pin = (ad_oe & ad_o) | (~ad_oe & (drv ? mem[addr] : idle));
endmodule : ext_mem_model

// *** verification/external_memory_interface_tb.sv ***
`timescale 1ns/100ps
`include "external_memory_port_defines.svh"
module external_memory_interface_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, compat_mode = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic mem_req = 1'b0, mem_we = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0] mem_wdata = 8'h00, port_ad_out = 8'h0f, port_ad_dir = 8'h3c;
  logic [7:0] port_ha_out = 8'h00, port_ha_dir = 8'h00;
  logic [2:0] port_ctl_out = 3'b011, port_ctl_dir = 3'b101;
  logic [1:0] slow = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_ack, mem_ext, ale_o, ale_oe, rd_n_o, rd_n_oe;
  logic wr_n_o, wr_n_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] mem_rdata, mux_addr_data_bus_i, mux_addr_data_bus_o;
  logic [7:0] mux_addr_data_bus_oe, high_address_bus_o, high_address_bus_oe;
  logic [7:0] ad_pullup_en, ad_keeper_en, ad_keeper_val;
  int bad_count = 0, tests_run = 0;

  external_memory_interface dut (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .compat_mode, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .mem_ext, .port_ad_out, .port_ad_dir, .port_ha_out,
    .port_ha_dir, .port_ctl_out, .port_ctl_dir, .mux_addr_data_bus_i,
    .mux_addr_data_bus_o, .mux_addr_data_bus_oe, .high_address_bus_o,
    .high_address_bus_oe, .ale_o, .ale_oe, .rd_n_o, .rd_n_oe, .wr_n_o,
    .wr_n_oe, .ad_pullup_en, .ad_keeper_en, .ad_keeper_val);

  ext_mem_model partner (
    .sys_clk, .slow, .ale(ale_o), .rd_n(rd_n_o), .wr_n(wr_n_o),
    .ad_o(mux_addr_data_bus_o), .ad_oe(mux_addr_data_bus_oe),
    .ha_o(high_address_bus_o), .ha_oe(high_address_bus_oe),
    .pull(ad_pullup_en), .keep_en(ad_keeper_en), .keep_val(ad_keeper_val),
    .ad_pin(mux_addr_data_bus_i));

  always #5 sys_clk = ~sys_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic guard(input int n);
    if (n >= 60) begin
      bad_count++;
      $display("ERROR %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : guard

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((!s_axi_awready && s_axi_awvalid ||
                !s_axi_wready && s_axi_wvalid) && n < 60);
    do begin @(posedge sys_clk); n++; end while (!s_axi_bvalid && n < 60);
    guard(n);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (!s_axi_arready && n < 60);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (!s_axi_rvalid && n < 60);
    guard(n);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, {24'h0, d});
    check(s_axi_rresp, er);
  endtask : axi_read

  // cyc below zero skips the latency comparison
  task automatic mem_access(input logic we, input logic [15:0] a,
    input logic [7:0] d, input logic [7:0] exp, input int cyc);
    int n;
    n = 0;
    @(posedge sys_clk);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge sys_clk);
    do begin @(posedge sys_clk); n++; end while (!mem_ack && n < 60);
    guard(n);
    mem_req <= 1'b0;
    if (cyc >= 0) check(n, cyc);
    if (!we) check(mem_rdata, exp);
  endtask : mem_access

  task automatic sc_regs;
    axi_read(`OFF_CTRL, `CTRL_RESET, `AXI_OKAY);
    axi_read(`OFF_XA, `XA_RESET, `AXI_OKAY);
    axi_read(`OFF_XB, `XB_RESET, `AXI_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_write(`OFF_CTRL, 8'hff, `AXI_OKAY);
    s_axi_wstrb <= 4'h1;
    axi_read(`OFF_CTRL, `CTRL_RESET, `AXI_OKAY);
    axi_write(`OFF_XA, 8'hff, `AXI_OKAY);
    axi_read(`OFF_XA, 8'h7e, `AXI_OKAY);
    axi_write(`OFF_XB, 8'hff, `AXI_OKAY);
    axi_read(`OFF_XB, 8'h87, `AXI_OKAY);
    axi_write(8'h10, 8'hff, `AXI_SLVERR);
    axi_read(8'h10, 8'h00, `AXI_SLVERR);
    axi_write(`OFF_XA, 8'h00, `AXI_OKAY);
    axi_write(`OFF_XB, 8'h00, `AXI_OKAY);
  endtask : sc_regs

  task automatic sc_disabled;
    @(posedge sys_clk);
    port_ad_out <= 8'hf0;
    mem_access(1'b0, 16'h9000, 8'h00, 8'h00, 1);
    check(mux_addr_data_bus_oe, 8'h3c);
    check(rd_n_oe, 1'b1);
    check(wr_n_oe, 1'b0);
  endtask : sc_disabled

  task automatic sc_waits;
    for (int c = 0; c < 4; c++) begin
      axi_write(`OFF_CTRL, {1'b1, c[0], 6'h00}, `AXI_OKAY);
      axi_write(`OFF_XA, {6'h00, c[1], 1'b0}, `AXI_OKAY);
      mem_access(1'b1, 16'h9000 + c, 8'h30 + c, 8'h00, 10 + c);
      mem_access(1'b0, 16'h9000 + c, 8'h00, 8'h30 + c, 10 + c);
    end
    check({rd_n_oe, wr_n_oe, ale_oe}, 3'b111);
    check(high_address_bus_oe, 8'hff);
    mem_access(1'b0, 16'h10ff, 8'h00, 8'h00, -1);
    check(mem_ext, 1'b0);
    mem_access(1'b1, 16'h1100, 8'h5c, 8'h00, 13);
    check(mem_ext, 1'b1);
  endtask : sc_waits

  task automatic sc_sectors;
    axi_write(`OFF_CTRL, 8'h80, `AXI_OKAY);
    axi_write(`OFF_XA, 8'h48, `AXI_OKAY);
    mem_access(1'b1, 16'h7fff, 8'ha5, 8'h00, 12);
    mem_access(1'b1, 16'h8000, 8'h5a, 8'h00, 10);
    axi_read(`OFF_STAT, 8'h06, `AXI_OKAY);
    @(posedge sys_clk);
    slow <= 2'h1;
    mem_access(1'b0, 16'h7fff, 8'h00, 8'ha5, 12);
    slow <= 2'h0;
  endtask : sc_sectors

  task automatic sc_mask;
    axi_write(`OFF_XB, 8'h83, `AXI_OKAY);
    @(posedge sys_clk);
    port_ha_out <= 8'ha0;
    repeat (3) @(posedge sys_clk);
    check(high_address_bus_oe, 8'h1f);
    check(high_address_bus_o[7:5], 3'b101);
    check(ad_keeper_en | mux_addr_data_bus_oe, 8'hff);
    mem_access(1'b1, 16'h0a55 + 16'h1000, 8'h77, 8'h00, 12);
    axi_write(`OFF_CTRL, 8'h00, `AXI_OKAY);
    repeat (3) @(posedge sys_clk);
    check(ad_keeper_en, 8'hc3);
    check(ad_keeper_val & 8'h3c, 8'h30);
    check(high_address_bus_oe, 8'h00);
  endtask : sc_mask

  task automatic sc_legacy;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    compat_mode <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    axi_read(`OFF_XA, 8'h00, `AXI_SLVERR);
    axi_write(`OFF_XB, 8'h80, `AXI_SLVERR);
    check(ad_keeper_en, 8'h00);
    check({rd_n_oe, wr_n_oe, ale_oe}, 3'b111);
    axi_write(`OFF_CTRL, 8'hc0, `AXI_OKAY);
    mem_access(1'b1, 16'h9100, 8'h11, 8'h00, 11);
    check(high_address_bus_oe, 8'hff);
  endtask : sc_legacy

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    sc_regs();
    sc_disabled();
    sc_waits();
    sc_sectors();
    sc_mask();
    sc_legacy();
    report_and_stop();
  end
endmodule : external_memory_interface_tb
